/* verilog/eqrl_pkg.sv */
package eqrl_pkg;
	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int EQRL_NPORT = 4;
	localparam int EQRL_NQUEUE = 3;
	localparam int EQRL_NREG = 12;
	// index = port * 3 + queue
	localparam logic [7:0] EQRL_OFS [EQRL_NREG] = '{
		8'hcb, 8'hcc, 8'hcd,
		8'hdb, 8'hdc, 8'hdd,
		8'heb, 8'hec, 8'hed,
		8'hfb, 8'hfc, 8'hfd
	};
	localparam logic [7:0] EQRL_OFS_RSVD_BB = 8'hbb;
	localparam logic [7:0] EQRL_OFS_RSVD_BC = 8'hbc;
	localparam logic [7:0] EQRL_OFS_RSVD_BD = 8'hbd;
	localparam int EQRL_LIMIT_LSB = 0;
	localparam int EQRL_LIMIT_W = 7;
	localparam logic [6:0] EQRL_LIMIT_RST = 7'h00;
	localparam logic [7:0] EQRL_RDATA_RST = 8'h00;

	// ---------------------------------------------------------------
	// rate table
	// ---------------------------------------------------------------
	localparam int EQRL_RATE_W = 17;
	localparam logic [6:0] EQRL_FULL_CODE_100 = 7'h64;
	localparam logic [6:0] EQRL_FULL_CODE_10 = 7'h0a;
	localparam logic [6:0] EQRL_SUB_BASE = 7'h64;
	localparam logic [6:0] EQRL_SUB_LAST_100 = 7'h73;
	localparam logic [16:0] EQRL_KBPS_PER_MBPS = 17'h003e8;
	localparam logic [16:0] EQRL_SUB_STEP_KBPS = 17'h00040;
	localparam logic [16:0] EQRL_FULL_KBPS_100 = 17'h186a0;
	localparam logic [16:0] EQRL_FULL_KBPS_10 = 17'h02710;
	localparam logic [16:0] EQRL_RATE_RST = 17'h00000;

	// ---------------------------------------------------------------
	// queue modes and ranks
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		EQRL_QM_ONE = 2'b00,
		EQRL_QM_TWO = 2'b01,
		EQRL_QM_FOUR = 2'b11
	} eqrl_qmode_e;
	localparam logic [1:0] EQRL_RANK_LOWEST = 2'h0;
	localparam logic [1:0] EQRL_RANK_SECOND = 2'h1;
	localparam logic [1:0] EQRL_RANK_THIRD = 2'h2;
endpackage : eqrl_pkg

/* verilog/eqrl_rate_decode.sv */
`timescale 1ns/100ps
module eqrl_rate_decode
	import eqrl_pkg::*;
(
	input wire logic [6:0] limit_in,
	input wire logic speed_100_in,
	output logic [16:0] rate_kbps_out
);
	logic [16:0] code_w;
	logic [16:0] mbps_w;
	logic [16:0] sub_w;

	assign code_w = {10'h000, limit_in};
	assign mbps_w = 17'(code_w * EQRL_KBPS_PER_MBPS);
	assign sub_w = 17'((code_w - {10'h000, EQRL_SUB_BASE}) * EQRL_SUB_STEP_KBPS);

	always_comb begin
		if (speed_100_in) begin
			// 100 mbit table
			if (limit_in == 7'h00 || limit_in == EQRL_FULL_CODE_100) begin
				rate_kbps_out = EQRL_FULL_KBPS_100;
			end else if (limit_in < EQRL_FULL_CODE_100) begin
				rate_kbps_out = mbps_w;
			end else if (limit_in <= EQRL_SUB_LAST_100) begin
				rate_kbps_out = sub_w;
			end else begin
				rate_kbps_out = EQRL_FULL_KBPS_100;
			end
		end else begin
			// 10 mbit table
			if (limit_in == 7'h00 || limit_in == EQRL_FULL_CODE_10) begin
				rate_kbps_out = EQRL_FULL_KBPS_10;
			end else if (limit_in < EQRL_FULL_CODE_10) begin
				rate_kbps_out = mbps_w;
			end else if (limit_in > EQRL_SUB_BASE) begin
				rate_kbps_out = sub_w;
			end else begin
				rate_kbps_out = EQRL_FULL_KBPS_10;
			end
		end
	end
endmodule : eqrl_rate_decode

/* verilog/eqrl_egress_limit.sv */
`timescale 1ns/100ps
// What this block does
// RQ1 - each port has a 7-bit queue 0 limit, reset zero, shaping queue 0.
// RQ2 - each port has a 7-bit queue 1 limit selecting its shaped rate.
// RQ3 - each port has a 7-bit queue 2 limit selecting its shaped rate.
// RQ4 - queue 0 is lowest of four, low of two.
// RQ5 - queue 1 is high of two, second lowest of four.
// RQ6 - queue 2 is second highest of four.
// RQ7 - at 100M: 1-99 Mbit, 0/100 full, 101-115 give 64k steps.
// RQ8 - at 10M: 1-9 Mbit, 0/10 full, 101 upward give 64k steps.
// RQ9 - with several queues only the top queue is exact, others ratio paced.
// RQ10 - bit 7 reads zero and ignores writes.
module eqrl_egress_limit
	import eqrl_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_hit_out,
	input wire logic [3:0] port_speed_100_in,
	input wire logic [1:0] port_qmode_in [EQRL_NPORT],
	output logic [6:0] limit_out [EQRL_NREG],
	output logic [16:0] rate_kbps_out [EQRL_NREG],
	output logic [1:0] rank_out [EQRL_NREG],
	output logic [EQRL_NREG-1:0] exact_out
);
	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	function automatic logic [4:0] eqrl_decode(input logic [7:0] addr);
		logic [4:0] res;
		if (addr == EQRL_OFS[0]) begin
			res = 5'h00;
		end else if (addr == EQRL_OFS[1]) begin
			res = 5'h01;
		end else if (addr == EQRL_OFS[2]) begin
			res = 5'h02;
		end else if (addr == EQRL_OFS[3]) begin
			res = 5'h03;
		end else if (addr == EQRL_OFS[4]) begin
			res = 5'h04;
		end else if (addr == EQRL_OFS[5]) begin
			res = 5'h05;
		end else if (addr == EQRL_OFS[6]) begin
			res = 5'h06;
		end else if (addr == EQRL_OFS[7]) begin
			res = 5'h07;
		end else if (addr == EQRL_OFS[8]) begin
			res = 5'h08;
		end else if (addr == EQRL_OFS[9]) begin
			res = 5'h09;
		end else if (addr == EQRL_OFS[10]) begin
			res = 5'h0a;
		end else if (addr == EQRL_OFS[11]) begin
			res = 5'h0b;
		end else begin
			res = 5'h1f;
		end
		return res;
	endfunction : eqrl_decode

	function automatic logic eqrl_is_rsvd(input logic [7:0] addr);
		logic res;
		if (addr == EQRL_OFS_RSVD_BB) begin
			res = 1'h1;
		end else if (addr == EQRL_OFS_RSVD_BC) begin
			res = 1'h1;
		end else if (addr == EQRL_OFS_RSVD_BD) begin
			res = 1'h1;
		end else begin
			res = 1'h0;
		end
		return res;
	endfunction : eqrl_is_rsvd

	logic [4:0] wr_idx_w;
	logic [4:0] rd_idx_w;
	logic [6:0] limit_r [EQRL_NREG];
	logic [7:0] reg_rdata_nxt;
	logic [EQRL_NREG-1:0] wr_sel_w;
	logic [6:0] wr_limit_w;
	eqrl_qmode_e qmode_w [EQRL_NPORT];

	assign wr_idx_w = eqrl_decode(reg_addr_in);
	assign rd_idx_w = wr_idx_w;
	assign reg_hit_out = (wr_idx_w != 5'h1f) || eqrl_is_rsvd(reg_addr_in);

	// ---------------------------------------------------------------
	// write select
	// ---------------------------------------------------------------
	// RQ10 top bit dropped
	assign wr_limit_w = reg_wdata_in[EQRL_LIMIT_LSB +: EQRL_LIMIT_W];

	always_comb begin
		for (int i = 0; i < EQRL_NREG; i++) begin
			wr_sel_w[i] = reg_wr_in && (wr_idx_w == 5'(i));
		end
	end

	// ---------------------------------------------------------------
	// per port mode
	// ---------------------------------------------------------------
	// RQ4 RQ9 unused code as one queue
	always_comb begin
		for (int i = 0; i < EQRL_NPORT; i++) begin
			if (port_qmode_in[i] == EQRL_QM_TWO) begin
				qmode_w[i] = EQRL_QM_TWO;
			end else if (port_qmode_in[i] == EQRL_QM_FOUR) begin
				qmode_w[i] = EQRL_QM_FOUR;
			end else begin
				qmode_w[i] = EQRL_QM_ONE;
			end
		end
	end

	// ---------------------------------------------------------------
	// per register storage and outputs
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < EQRL_NREG; g++) begin : g_reg
			localparam int PORT = g / EQRL_NQUEUE;
			localparam int QUEUE = g % EQRL_NQUEUE;
			logic [16:0] rate_w;
			logic [1:0] rank_nxt;
			logic exact_nxt;

			// RQ1 RQ2 RQ3 limit field store
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					limit_r[g] <= EQRL_LIMIT_RST;
				end else if (wr_sel_w[g]) begin
					limit_r[g] <= wr_limit_w;
				end
			end

			// RQ7 RQ8 table lookup
			eqrl_rate_decode u_dec (
				.limit_in(limit_r[g]),
				.speed_100_in(port_speed_100_in[PORT]),
				.rate_kbps_out(rate_w)
			);

			always_comb begin
				rank_nxt = EQRL_RANK_LOWEST;
				exact_nxt = 1'b0;
				case (qmode_w[PORT])
					EQRL_QM_FOUR: begin
						// RQ4 RQ5 RQ6 four queue ranks
						if (QUEUE == 1) begin
							rank_nxt = EQRL_RANK_SECOND;
						end else if (QUEUE == 2) begin
							rank_nxt = EQRL_RANK_THIRD;
						end
						// RQ9 queue 3 is the exact one
						exact_nxt = 1'b0;
					end
					EQRL_QM_TWO: begin
						// RQ4 RQ5 two queue ranks
						if (QUEUE == 1) begin
							rank_nxt = EQRL_RANK_SECOND;
						end
						// RQ9 queue 1 is the exact one
						exact_nxt = (QUEUE == 1);
					end
					EQRL_QM_ONE: begin
						// RQ9 single queue is exact
						exact_nxt = (QUEUE == 0);
					end
					default: begin
						exact_nxt = (QUEUE == 0);
					end
				endcase
			end

			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					rate_kbps_out[g] <= EQRL_RATE_RST;
				end else begin
					rate_kbps_out[g] <= rate_w;
				end
			end

			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					rank_out[g] <= EQRL_RANK_LOWEST;
				end else begin
					rank_out[g] <= rank_nxt;
				end
			end

			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					exact_out[g] <= 1'h0;
				end else begin
					exact_out[g] <= exact_nxt;
				end
			end

			assign limit_out[g] = limit_r[g];
		end
	endgenerate

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	always_comb begin
		reg_rdata_nxt = EQRL_RDATA_RST;
		// RQ10 bit 7 reads zero
		if (rd_idx_w < 5'(EQRL_NREG)) begin
			reg_rdata_nxt = {1'b0, limit_r[rd_idx_w[3:0]]};
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= EQRL_RDATA_RST;
		end else if (reg_rd_in) begin
			reg_rdata_out <= reg_rdata_nxt;
		end
	end
endmodule : eqrl_egress_limit

/* testbench/eqrl_props.sv */
`timescale 1ns/100ps
module eqrl_props
	import eqrl_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic [3:0] port_speed_100_in,
	input wire logic [1:0] port_qmode_in [EQRL_NPORT],
	input wire logic [6:0] limit_out [EQRL_NREG],
	input wire logic [16:0] rate_kbps_out [EQRL_NREG],
	input wire logic [1:0] rank_out [EQRL_NREG],
	input wire logic [EQRL_NREG-1:0] exact_out
);
	// ----
	// checks
	// ----
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_wr(a);
		reg_wr_in && reg_addr_in == a;
	endsequence
	property p_wq0;
		s_wr(8'hcb) |=> limit_out[0] == $past(reg_wdata_in[6:0]);
	endproperty
	a_wq0: assert property (p_wq0) else $error("q0 write");
	property p_wq1;
		s_wr(8'hdc) |=> limit_out[4] == $past(reg_wdata_in[6:0]);
	endproperty
	a_wq1: assert property (p_wq1) else $error("q1 write");
	property p_wq2;
		s_wr(8'hfd) |=> limit_out[11] == $past(reg_wdata_in[6:0]);
	endproperty
	a_wq2: assert property (p_wq2) else $error("q2 write");
	property p_rd;
		reg_rd_in && reg_addr_in == 8'hcb |=> reg_rdata_out == {1'b0, $past(limit_out[0])};
	endproperty
	a_rd: assert property (p_rd) else $error("read back");
	property p_rk4;
		port_qmode_in[1] == EQRL_QM_FOUR |=> rank_out[3] == 2'h0 && rank_out[4] == 2'h1
			&& rank_out[5] == 2'h2;
	endproperty
	a_rk4: assert property (p_rk4) else $error("four rank");
	property p_ex2;
		port_qmode_in[2] == EQRL_QM_TWO |=> exact_out[8:6] == 3'h2 && rank_out[7] == 2'h1;
	endproperty
	a_ex2: assert property (p_ex2) else $error("two exact");
	property p_sub;
		limit_out[9] == 7'h65 |=> rate_kbps_out[9] == EQRL_SUB_STEP_KBPS;
	endproperty
	a_sub: assert property (p_sub) else $error("sub rate");
	property p_full;
		limit_out[0] == 7'h00 |=> rate_kbps_out[0] == ($past(port_speed_100_in[0]) ?
			EQRL_FULL_KBPS_100 : EQRL_FULL_KBPS_10);
	endproperty
	a_full: assert property (p_full) else $error("full rate");
endmodule : eqrl_props
bind eqrl_egress_limit eqrl_props i_props (.clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in,
	.reg_wdata_in, .reg_rd_in, .reg_rdata_out, .port_speed_100_in, .port_qmode_in, .limit_out,
	.rate_kbps_out, .rank_out, .exact_out);

/* testbench/egress_queue_rate_limit_tb_top.sv */
`timescale 1ns/100ps
module egress_queue_rate_limit_tb_top
	import eqrl_pkg::*;
;
	logic clk_in = 1'h0, rst_n_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0, reg_hit_out;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
	logic [3:0] port_speed_100_in = 4'h0;
	logic [1:0] port_qmode_in [EQRL_NPORT] = '{default: 2'h0};
	logic [6:0] limit_out [EQRL_NREG];
	logic [16:0] rate_kbps_out [EQRL_NREG];
	logic [1:0] rank_out [EQRL_NREG];
	logic [EQRL_NREG-1:0] exact_out;
	int n_fail = 0, checked = 0, cyc = 0, seed = 32'h5de147ea, m [EQRL_NREG];
	initial forever #10 clk_in = ~clk_in;
	eqrl_egress_limit i_dut (.clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
		.reg_rd_in, .reg_rdata_out, .reg_hit_out, .port_speed_100_in, .port_qmode_in,
		.limit_out, .rate_kbps_out, .rank_out, .exact_out);
	function automatic int rt(int c, bit s);
		if (c > 100 && (!s || c < 116))
			return (c - 100) * 64;
		if (c > 0 && c < (s ? 100 : 10))
			return c * 1000;
		return s ? 100000 : 10000;
	endfunction : rt
	task automatic chk(string n, int e, logic [16:0] g);
		checked++;
		if (g !== 17'(e)) begin
			n_fail++;
			$display("BAD %s exp %0h got %0h", n, e, g);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d fails %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop;
		end
	end
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'h1;
		@(negedge clk_in);
		reg_wr_in = 1'h0;
	endtask : wr
	task automatic rd(logic [7:0] a, int e, bit h);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_rd_in = 1'h1;
		#1 chk("hit", h, reg_hit_out);
		@(negedge clk_in);
		reg_rd_in = 1'h0;
		chk("rdata", e, reg_rdata_out);
	endtask : rd
	task automatic all;
		@(negedge clk_in);
		for (int k = 0; k < EQRL_NREG; k++) begin
			int q = k % 3;
			int md = port_qmode_in[k / 3];
			chk("limit", m[k], limit_out[k]);
			chk("rate", rt(m[k], port_speed_100_in[k / 3]), rate_kbps_out[k]);
			chk("rank", md == 3 ? q : md == 1 && q == 1, rank_out[k]);
			chk("exact", md == 3 ? 0 : md == 1 ? q == 1 : q == 0, exact_out[k]);
		end
	endtask : all
	initial begin
		m = '{default: 0};
		repeat (5) @(negedge clk_in);
		rst_n_in = 1'h1;
		all;
		for (int k = 0; k < 15; k++)
			rd(k < 12 ? EQRL_OFS[k] : 8'hbb + 8'(k - 12), 0, 1'h1);
		rd(8'h07, 0, 1'h0);
		$display("test reset end");
		port_speed_100_in = 4'hf;
		wr(EQRL_OFS[8], 8'h64);
		m[8] = 100;
		wr(EQRL_OFS[9], 8'he5);
		m[9] = 101;
		wr(EQRL_OFS[10], 8'h74);
		m[10] = 116;
		wr(EQRL_OFS[11], 8'h73);
		m[11] = 115;
		all;
		port_speed_100_in = 4'h0;
		all;
		$display("test table end");
		repeat (300) begin
			int k;
			logic [7:0] d;
			k = $unsigned($random(seed)) % EQRL_NREG;
			d = 8'($random(seed));
			port_speed_100_in = 4'($random(seed));
			port_qmode_in[k / 3] = 2'($random(seed));
			wr(EQRL_OFS[k], d);
			m[k] = d[6:0];
			wr(k % 2 ? 8'hbc : 8'h3f, 8'($random(seed)));
			all;
			rd(EQRL_OFS[k], m[k], 1'h1);
		end
		$display("test random end");
		rst_n_in = 1'h0;
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'h1;
		m = '{default: 0};
		all;
		$display("test rereset end");
		report_and_stop;
	end
endmodule : egress_queue_rate_limit_tb_top
